/* touch_detect_pkg.sv */
// constants, field layout and types for the touch qualification block
// assumes a single 25 MHz core clock and an SMBus-style two-wire register port
package touch_detect_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] QUEUE_ADDR      = 8'h1E;
	localparam logic [7:0] GAIN_ADDR       = 8'h1F;
	localparam logic [7:0] OPTIONS_ADDR    = 8'h20;
	localparam logic [7:0] SLIDER_ADDR     = 8'h06;
	localparam logic [7:0] DELTA_BASE_ADDR = 8'h10;

	// ------------------------------------------------------------
	// reset values and writable bits
	// ------------------------------------------------------------
	localparam logic [7:0] QUEUE_RESET   = 8'h03;
	localparam logic [7:0] GAIN_RESET    = 8'h2F;
	localparam logic [7:0] OPTIONS_RESET = 8'h29;
	localparam logic [7:0] SLIDER_RESET  = 8'h00;
	localparam logic [7:0] QUEUE_WMASK   = 8'h07;
	localparam logic [7:0] GAIN_WMASK    = 8'h7F;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int QUEUE_LSB   = 0;
	localparam int GAIN_LSB    = 4;
	localparam int SHIFT_LSB   = 0;
	localparam int TIMEOUT_BIT = 7;
	localparam int POSVOL_BIT  = 6;

	localparam logic [3:0] SHIFT_MAX     = 4'h8;
	localparam logic [2:0] GAIN_MIN_CODE = 3'h7;
	localparam logic [7:0] DELTA_POS_CAP = 8'h7F;
	localparam logic [7:0] DELTA_NEG_CAP = 8'hFF;
	localparam logic [6:0] SLIDER_MAX    = 7'h7F;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ          = 25000000;
	localparam int SCL_LOW_MS      = 30;
	localparam int BUS_IDLE_US     = 150;
	localparam int SCL_LOW_CYCLES  = (CLK_HZ / 1000) * SCL_LOW_MS;
	localparam int BUS_IDLE_CYCLES = (CLK_HZ / 1000000) * BUS_IDLE_US;

	typedef logic [2:0] queue_code_t;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_ADDR      = 4'h1,
		ST_ADDR_ACK  = 4'h2,
		ST_CMD       = 4'h3,
		ST_CMD_ACK   = 4'h4,
		ST_WDATA     = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA     = 4'h7,
		ST_RDATA_ACK = 4'h8,
		ST_IGNORE    = 4'h9
	} bus_state_t;

endpackage : touch_detect_pkg

/* qual_if.sv */
// per-channel link between the sample path and one qualification counter
// assumes both ends run on the same core clock
`timescale 1ns/10ps
`default_nettype none

interface qual_if;
	logic        strobe;
	logic        above;
	logic [2:0]  needCount;
	logic        touched;

	modport core (output strobe, output above, output needCount, input touched);
	modport chan (input strobe, input above, input needCount, output touched);
endinterface : qual_if

`default_nettype wire

/* touch_qualifier.sv */
// one channel's consecutive-sample queue for touch and release
// assumes strobe is a one-cycle pulse per sensing cycle on clk
`timescale 1ns/10ps
`default_nettype none

module touch_qualifier (
	input  wire logic clk,
	input  wire logic rst,
	qual_if.chan      q
);
	import touch_detect_pkg::*;

	logic [2:0] run_q;
	logic       touched_q;
	logic [2:0] runNext;
	logic       change;
	logic       done;

	assign change  = q.above != touched_q;
	assign runNext = run_q + 3'h1;
	assign done    = runNext >= q.needCount;
	assign q.touched = touched_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			run_q     <= 3'h0;
			touched_q <= 1'b0;
		end else if (q.strobe) begin
			if (change && done) begin
				touched_q <= q.above;
				run_q     <= 3'h0;
			end else if (change) begin
				run_q <= runNext;
			end else begin
				run_q <= 3'h0;
			end
		end
	end

endmodule : touch_qualifier

`default_nettype wire

/* touch_detect_config.sv */
// touch qualification, gain and base scaling, slider value and two-wire register port
// assumes scl/sda come from pins; sample inputs are synchronous to clk
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - touch after N consecutive above-threshold samples
// - release after N consecutive samples below
// - each channel has its own counter
// - queue codes 0 and 1 mean one
// - gain code bits 6:4, 128x down to 1x
// - gain scales delta before threshold compare
// - base count shifted by code, capped 256x
// - base scaling never affects detection
// - timeout bit low disables both bus timeouts
// - clock low over 30 ms aborts transfer
// - both lines high 150 us resets bus
// - deep sleep: no idle reset, wait stop
// - position mode reports last grouped sensor touched
// - volume mode: slider value host-writable
// - one gain setting for all channels
// - delta saturates at 7Fh and FFh
// - delta updated once per sensing cycle
module touch_detect_config #(
	parameter int         NUM_CH         = 14,
	parameter int         RAW_W          = 16,
	parameter int         GROUP_LO       = 7,
	parameter int         SCL_LOW_LIMIT  = touch_detect_pkg::SCL_LOW_CYCLES,
	parameter logic [6:0] DEV_ADDR       = 7'h2A  // arbitrary value
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    sclIn,
	input  wire logic                    sdaIn,
	output logic                         sdaOut,
	output logic                         sdaOe,
	input  wire logic                    deepSleep,
	input  wire logic                    sampleValid,
	input  wire logic [NUM_CH*RAW_W-1:0] deltaRaw,
	input  wire logic [NUM_CH*RAW_W-1:0] baseRaw,
	input  wire logic [7:0]              touchThreshold,
	output logic [NUM_CH-1:0]            touched,
	output logic [NUM_CH*8-1:0]          deltaCount,
	output logic [NUM_CH*8-1:0]          baseCount,
	output logic [6:0]                   sliderValue
);
	import touch_detect_pkg::*;

	localparam int SL_W = $clog2(SCL_LOW_LIMIT + 1);
	localparam int ID_W = $clog2(BUS_IDLE_CYCLES + 1);

	if (NUM_CH < 1 || NUM_CH > 16 || GROUP_LO >= NUM_CH || GROUP_LO < 0
		|| RAW_W < 8 || RAW_W > 24 || SCL_LOW_LIMIT < 2) begin : g_bad_param
		$error("touch_detect_config: unsupported parameter values");
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0]  queue_q;
	logic [7:0]  gain_q;
	logic [7:0]  options_q;
	logic [6:0]  slider_q;
	logic [6:0]  lastPos_q;

	queue_code_t queueCode;
	logic [2:0]  needCount;
	logic [2:0]  gainCode;
	logic [2:0]  gainShift;
	logic [3:0]  shiftCode;
	logic [3:0]  shiftEff;
	logic        timeoutEn;
	logic        volMode;

	assign queueCode = queue_q[QUEUE_LSB +: 3];
	assign needCount = (queueCode < 3'h2) ? 3'h1 : queueCode;
	assign gainCode  = gain_q[GAIN_LSB +: 3];
	assign gainShift = GAIN_MIN_CODE - gainCode;
	assign shiftCode = gain_q[SHIFT_LSB +: 4];
	assign shiftEff  = (shiftCode > SHIFT_MAX) ? SHIFT_MAX : shiftCode;
	assign timeoutEn = options_q[TIMEOUT_BIT];
	assign volMode   = options_q[POSVOL_BIT];

	// ------------------------------------------------------------
	// pin synchronisers and line events
	// ------------------------------------------------------------
	logic [1:0] sclSync_q;
	logic [1:0] sdaSync_q;
	logic       sclPrev_q;
	logic       sdaPrev_q;
	logic       sclS;
	logic       sdaS;
	logic       sclRise;
	logic       sclFall;
	logic       startSeen;
	logic       stopSeen;

	always_ff @(posedge clk) begin
		if (rst) begin
			sclSync_q <= 2'h3;
			sdaSync_q <= 2'h3;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], sclIn};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			sclPrev_q <= sclSync_q[1];
			sdaPrev_q <= sdaSync_q[1];
		end
	end

	assign sclS      = sclSync_q[1];
	assign sdaS      = sdaSync_q[1];
	assign sclRise   = sclS && !sclPrev_q;
	assign sclFall   = !sclS && sclPrev_q;
	assign startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign stopSeen  = sclS && sclPrev_q && !sdaPrev_q && sdaS;

	// ------------------------------------------------------------
	// bus timeouts
	// ------------------------------------------------------------
	logic [SL_W-1:0] sclLow_q;
	logic [ID_W-1:0] idle_q;
	logic            sclTimeout;
	logic            idleReset;

	always_ff @(posedge clk) begin
		if (rst || !timeoutEn || sclS) sclLow_q <= '0;
		else if (!sclTimeout) sclLow_q <= sclLow_q + SL_W'(1);
	end

	always_ff @(posedge clk) begin
		if (rst || !timeoutEn || !(sclS && sdaS)) idle_q <= '0;
		else if (!idleReset) idle_q <= idle_q + ID_W'(1);
	end

	// a stuck-low clock is caught as soon as the count reaches the limit
	assign sclTimeout = sclLow_q == SL_W'(SCL_LOW_LIMIT);
	// deep sleep keeps the protocol state through long idles
	assign idleReset  = (idle_q == ID_W'(BUS_IDLE_CYCLES)) && !deepSleep;

	// ------------------------------------------------------------
	// two-wire slave state machine
	// ------------------------------------------------------------
	bus_state_t st_q;
	logic [7:0] sh_q;
	logic [3:0] bitCnt_q;
	logic       ackPhase_q;
	logic       isRead_q;
	logic       masterAck_q;
	logic [7:0] ptr_q;
	logic       sdaOe_q;
	logic       sdaOut_q;
	logic [7:0] byteIn;
	logic [7:0] readData;
	logic       lastBit;
	logic       busAbort;
	logic       startOk;
	logic       wrEn;
	logic [2:0] outIdx;

	assign byteIn   = {sh_q[6:0], sdaS};
	assign lastBit  = sclRise && (bitCnt_q == 4'h7);
	assign busAbort = sclTimeout || idleReset;
	// while asleep, traffic for others is ignored up to the next stop
	assign startOk  = startSeen && !(deepSleep && st_q == ST_IGNORE);
	assign wrEn     = (st_q == ST_WDATA) && lastBit && !busAbort && !startSeen && !stopSeen;
	assign outIdx   = 3'(4'h7 - bitCnt_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q        <= ST_IDLE;
			sh_q        <= 8'h00;
			bitCnt_q    <= 4'h0;
			ackPhase_q  <= 1'b0;
			isRead_q    <= 1'b0;
			masterAck_q <= 1'b0;
			ptr_q       <= 8'h00;
			sdaOe_q     <= 1'b0;
			sdaOut_q    <= 1'b0;
		end else if (busAbort) begin
			st_q    <= ST_IDLE;
			sdaOe_q <= 1'b0;
		end else if (startOk) begin
			st_q       <= ST_ADDR;
			bitCnt_q   <= 4'h0;
			ackPhase_q <= 1'b0;
			sdaOe_q    <= 1'b0;
		end else if (stopSeen) begin
			st_q    <= ST_IDLE;
			sdaOe_q <= 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_IGNORE: begin
				end
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (sclRise) begin
						sh_q     <= byteIn;
						bitCnt_q <= bitCnt_q + 4'h1;
					end
					if (lastBit) begin
						ackPhase_q <= 1'b0;
						if (st_q == ST_ADDR && byteIn[7:1] == DEV_ADDR) begin
							isRead_q <= byteIn[0];
							st_q     <= ST_ADDR_ACK;
						end else if (st_q == ST_ADDR) begin
							st_q <= ST_IGNORE;
						end else if (st_q == ST_CMD) begin
							ptr_q <= byteIn;
							st_q  <= ST_CMD_ACK;
						end else begin
							ptr_q <= ptr_q + 8'h01;
							st_q  <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
					if (sclFall && !ackPhase_q) begin
						sdaOe_q    <= 1'b1;
						ackPhase_q <= 1'b1;
					end else if (sclFall) begin
						ackPhase_q <= 1'b0;
						bitCnt_q   <= 4'h0;
						if (st_q == ST_ADDR_ACK && isRead_q) begin
							sh_q     <= readData;
							sdaOe_q  <= !readData[7];
							bitCnt_q <= 4'h1;
							st_q     <= ST_RDATA;
						end else begin
							sdaOe_q <= 1'b0;
							st_q    <= (st_q == ST_ADDR_ACK) ? ST_CMD : ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (sclFall && bitCnt_q < 4'h8) begin
						sdaOe_q  <= !sh_q[outIdx];
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall) begin
						sdaOe_q <= 1'b0;
						ptr_q   <= ptr_q + 8'h01;
						st_q    <= ST_RDATA_ACK;
					end
				end
				ST_RDATA_ACK: begin
					if (sclRise) masterAck_q <= !sdaS;
					if (sclFall && masterAck_q) begin
						sh_q     <= readData;
						sdaOe_q  <= !readData[7];
						bitCnt_q <= 4'h1;
						st_q     <= ST_RDATA;
					end else if (sclFall) begin
						st_q <= ST_IGNORE;
					end
				end
			endcase
		end
	end

	assign sdaOe  = sdaOe_q;
	assign sdaOut = sdaOut_q;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	logic wrQueue;
	logic wrGain;
	logic wrOptions;
	logic wrSlider;

	assign wrQueue   = wrEn && ptr_q == QUEUE_ADDR;
	assign wrGain    = wrEn && ptr_q == GAIN_ADDR;
	assign wrOptions = wrEn && ptr_q == OPTIONS_ADDR;
	assign wrSlider  = wrEn && ptr_q == SLIDER_ADDR && volMode;

	always_ff @(posedge clk) begin
		if (rst) begin
			queue_q   <= QUEUE_RESET;
			gain_q    <= GAIN_RESET;
			options_q <= OPTIONS_RESET;
		end else begin
			if (wrQueue) queue_q <= byteIn & QUEUE_WMASK;
			if (wrGain) gain_q <= byteIn & GAIN_WMASK;
			if (wrOptions) options_q <= byteIn;
		end
	end

	// ------------------------------------------------------------
	// per-channel delta, base count and qualification
	// ------------------------------------------------------------
	logic [7:0]        deltaArr_q [NUM_CH];
	logic [NUM_CH-1:0] touchedVec;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
		logic signed [RAW_W+7:0] ext;
		logic signed [RAW_W+7:0] scaled;
		logic [7:0]              deltaSat;
		logic [RAW_W-1:0]        baseShifted;
		logic [7:0]              baseSat;
		logic [7:0]              base_q;
		qual_if                  qi ();

		assign ext    = {{8{deltaRaw[c*RAW_W+RAW_W-1]}}, deltaRaw[c*RAW_W +: RAW_W]};
		// one shared gain for every channel
		assign scaled = ext <<< gainShift;
		assign deltaSat = scaled[RAW_W+7] ? DELTA_NEG_CAP
			: (|scaled[RAW_W+6:7]) ? DELTA_POS_CAP : scaled[7:0];

		// display-only path; nothing below feeds the qualifier
		assign baseShifted = baseRaw[c*RAW_W +: RAW_W] >> shiftEff;
		assign baseSat     = (|baseShifted[RAW_W-1:8]) ? 8'hFF : baseShifted[7:0];

		assign qi.strobe    = sampleValid;
		assign qi.above     = !deltaSat[7] && ({1'b0, deltaSat[6:0]} > touchThreshold);
		assign qi.needCount = needCount;
		assign touchedVec[c] = qi.touched;

		touch_qualifier u_qual (
			.clk (clk),
			.rst (rst),
			.q   (qi.chan)
		);

		always_ff @(posedge clk) begin
			if (rst) begin
				deltaArr_q[c] <= 8'h00;
				base_q        <= 8'h00;
			end else if (sampleValid) begin
				deltaArr_q[c] <= deltaSat;
				base_q        <= baseSat;
			end
		end

		assign deltaCount[c*8 +: 8] = deltaArr_q[c];
		assign baseCount[c*8 +: 8]  = base_q;
	end

	assign touched = touchedVec;

	// ------------------------------------------------------------
	// slider value
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] touchedPrev_q;
	logic [NUM_CH-1:0] newTouch;
	logic              hit;
	logic [6:0]        posNum;

	assign newTouch = touchedVec & ~touchedPrev_q;

	always_comb begin
		hit    = 1'b0;
		posNum = 7'h00;
		for (int i = GROUP_LO; i < NUM_CH; i++) begin
			if (newTouch[i]) begin
				hit    = 1'b1;
				posNum = 7'(i - GROUP_LO + 1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			touchedPrev_q <= '0;
			lastPos_q     <= 7'h00;
			slider_q      <= SLIDER_RESET[6:0];
		end else begin
			touchedPrev_q <= touchedVec;
			// a sensor event outranks a host write landing in the same cycle
			if (hit) begin
				lastPos_q <= posNum;
				if (!volMode) slider_q <= posNum;
				else if (posNum > lastPos_q && slider_q != SLIDER_MAX) slider_q <= slider_q + 7'h01;
				else if (posNum < lastPos_q && slider_q != 7'h00) slider_q <= slider_q - 7'h01;
			end else if (wrSlider) begin
				slider_q <= byteIn[6:0];
			end
		end
	end

	assign sliderValue = slider_q;

	// ------------------------------------------------------------
	// read data selection
	// ------------------------------------------------------------
	logic       isDelta;
	logic [3:0] deltaIdx;

	assign isDelta  = ptr_q >= DELTA_BASE_ADDR && ptr_q < DELTA_BASE_ADDR + 8'(NUM_CH);
	assign deltaIdx = 4'(ptr_q - DELTA_BASE_ADDR);
	assign readData = isDelta ? deltaArr_q[deltaIdx]
		: (ptr_q == QUEUE_ADDR) ? queue_q
		: (ptr_q == GAIN_ADDR) ? gain_q
		: (ptr_q == OPTIONS_ADDR) ? options_q
		: (ptr_q == SLIDER_ADDR) ? {1'b0, slider_q}
		: 8'h00;

endmodule : touch_detect_config

`default_nettype wire

/* touch_detect_config_asserts.sv */
// port assertions for the touch qualification block
// assumes one clock domain; bound onto touch_detect_config
`timescale 1ns/10ps
`default_nettype none

module touch_detect_config_asserts #(
	parameter int NUM_CH = 14
) (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                sampleValid,
	input wire logic [7:0]          touchThreshold,
	input wire logic [NUM_CH-1:0]   touched,
	input wire logic [NUM_CH*8-1:0] deltaCount,
	input wire logic [NUM_CH*8-1:0] baseCount
);
	import touch_detect_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// presented counts
	// ------------------------------------------------------------
	chk_delta_hold: assert property (!$past(sampleValid) |-> $stable(deltaCount))
		else $error("delta moved without a sample");
	chk_base_hold: assert property ($changed(baseCount) |-> $past(sampleValid))
		else $error("base moved without a sample");
	chk_neg_cap_low: assert property (deltaCount[7] |-> deltaCount[7:0] == DELTA_NEG_CAP)
		else $error("negative delta not capped");
	// a grouped channel, the one the bench drives negative
	chk_neg_cap_high: assert property (deltaCount[79] |->
		deltaCount[79:72] == DELTA_NEG_CAP)
		else $error("negative delta not capped on a grouped channel");

	// ------------------------------------------------------------
	// qualification
	// ------------------------------------------------------------
	// touched may only move a few cycles after a sensing strobe
	chk_touch_timing: assert property ($changed(touched) |->
		$past(sampleValid) || $past(sampleValid, 2) || $past(sampleValid, 3)
		|| $past(sampleValid, 4))
		else $error("touch state moved without a sample");
	chk_touch_cause: assert property ($rose(touched[0]) |->
		!deltaCount[7] && (deltaCount[7:0] > touchThreshold))
		else $error("touch without delta above threshold");
	chk_release_cause: assert property ($fell(touched[0]) |->
		deltaCount[7] || (deltaCount[7:0] <= touchThreshold))
		else $error("release while delta above threshold");
	chk_chan_own: assert property ($rose(touched[1]) |->
		!deltaCount[15] && (deltaCount[15:8] > touchThreshold))
		else $error("second channel touched by foreign delta");
endmodule : touch_detect_config_asserts

bind touch_detect_config touch_detect_config_asserts #(.NUM_CH(NUM_CH)) i_chk (
	.clk(clk), .rst(rst), .sampleValid(sampleValid), .touchThreshold(touchThreshold),
	.touched(touched), .deltaCount(deltaCount), .baseCount(baseCount));

`default_nettype wire

/* smbus_host_model.sv */
// two-wire bus host that configures the touch block
// assumes a pull-up on data; clock stands high between frames
`timescale 1ns/10ps
`default_nettype none

module smbus_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
	input  wire logic sdaOe,
	output logic      sclIn,
	output logic      sdaIn
);
	logic sclLow;
	logic dataLow;

	// open drain: either party pulling low wins over the pull-up
	assign sdaIn = !(dataLow || sdaOe);
	assign sclIn = !sclLow;

	initial begin
		sclLow = 1'b0;
		dataLow = 1'b0;
	end

	// one 320 ns bit; data only moves while the clock is low
	task automatic bitIo(input logic b, output logic r);
		sclLow = 1'b1;
		#80 dataLow = !b;
		#80 sclLow = 1'b0;
		#80 r = sdaIn;
		#80;
	endtask : bitIo

	task automatic start();
		sclLow = 1'b1;
		#80 dataLow = 1'b0;
		#80 sclLow = 1'b0;
		#80 dataLow = 1'b1;
		#80;
	endtask : start

	task automatic stop();
		sclLow = 1'b1;
		#80 dataLow = 1'b1;
		#80 sclLow = 1'b0;
		#80 dataLow = 1'b0;
		#160;
	endtask : stop

	task automatic idle(input logic low, input int t);
		sclLow = low;
		#t;
	endtask : idle

	// msb first, then one release bit that samples the acknowledge
	task automatic byteIo(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
		bitIo(1'b1, a);
		ack = !a;
	endtask : byteIo

	// slider writes count only in volume mode; the bench chooses when
	task automatic writeReg(input logic [7:0] a, input logic [7:0] d, output logic ack);
		logic [7:0] r;
		logic [2:0] k;
		start();
		byteIo({DEV_ADDR, 1'b0}, r, k[0]);
		byteIo(a, r, k[1]);
		byteIo(d, r, k[2]);
		stop();
		ack = &k;
	endtask : writeReg

	task automatic readReg(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic       k;
		start();
		byteIo({DEV_ADDR, 1'b0}, r, k);
		byteIo(a, r, k);
		start();
		byteIo({DEV_ADDR, 1'b1}, r, k);
		byteIo(8'hFF, d, k);
		stop();
	endtask : readReg
endmodule : smbus_host_model

`default_nettype wire

/* tb_touch_detect_config.sv */
// self-checking bench for the touch qualification block
// assumes the host model drives the bus pins at a 320 ns bit time
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_touch_detect_config;
	import touch_detect_pkg::*;

	localparam logic [6:0] ADDR = 7'h2A;  // arbitrary value
	localparam logic [5:0] RUN0 = 6'b111011;
	localparam logic [5:0] RUN1 = 6'b001110;
	localparam logic [3:0] STALLS [5] = '{4'h1, 4'h8, 4'hC, 4'hF, 4'h5};

	logic         clk;
	logic         rst;
	logic         deepSleep;
	logic         sampleValid;
	logic [223:0] deltaRaw;
	logic [223:0] baseRaw;
	logic [7:0]   touchThreshold;
	wire logic    sclIn;
	wire logic    sdaIn;
	wire logic    sdaOe;
	wire logic    sdaOut;
	wire logic [13:0]  touched;
	wire logic [111:0] deltaCount;
	wire logic [111:0] baseCount;
	wire logic [6:0]   sliderValue;
	int           fails;
	int           checkCount;
	int           cycles;
	int           n;
	int           sh;
	logic         ack;
	logic [7:0]   rd;
	logic [7:0]   exp;

	touch_detect_config #(.SCL_LOW_LIMIT(200), .DEV_ADDR(ADDR)) i_dut (
		.clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.deepSleep(deepSleep), .sampleValid(sampleValid), .deltaRaw(deltaRaw),
		.baseRaw(baseRaw), .touchThreshold(touchThreshold), .touched(touched),
		.deltaCount(deltaCount), .baseCount(baseCount), .sliderValue(sliderValue));

	smbus_host_model #(.DEV_ADDR(ADDR)) i_host (.sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

	// ------------------------------------------------------------
	// access and stimulus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.writeReg(a, d, ack);
		`CHK("write ack", 1'b1, ack)
	endtask : wr

	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		i_host.readReg(a, rd);
		`CHK("register read", e, rd)
	endtask : rdChk

	// channels 0, 1 and 9 carry data; the rest stay at zero
	task automatic sample(input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d9);
		@(posedge clk);
		deltaRaw <= {64'h0, d9, 112'h0, d1, d0};
		sampleValid <= 1'b1;
		@(posedge clk);
		sampleValid <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask : sample

	// c = {timeout on, stall high, deep sleep, ack expected}
	task automatic stall(input logic [3:0] c);
		logic [7:0] r;
		logic       a;
		wr(OPTIONS_ADDR, {c[3], 7'h29});
		@(posedge clk);
		deepSleep <= c[1];
		// pin edges stay clear of the sampling clock edge
		#1;
		i_host.start();
		i_host.byteIo({ADDR, 1'b0}, r, a);
		i_host.bitIo(1'b1, a);
		i_host.idle(!c[2], c[2] ? 160000 : 12000);
		for (int i = 0; i < 7; i++) i_host.bitIo(1'b0, a);
		i_host.bitIo(1'b1, a);
		`CHK("ack after stall", c[0], !a)
		i_host.stop();
		@(posedge clk);
		deepSleep <= 1'b0;
		#1;
	endtask : stall

	task automatic end_of_test();
		if (fails == 0 && checkCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// a hang costs one mismatch and closes the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fails++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		deepSleep = 1'b0;
		sampleValid = 1'b0;
		deltaRaw = '0;
		baseRaw = {14{16'h1000}};
		touchThreshold = 8'h20;
		fails = 0;
		checkCount = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		rdChk(QUEUE_ADDR, 8'h03);
		rdChk(GAIN_ADDR, 8'h2F);
		rdChk(OPTIONS_ADDR, 8'h29);
		wr(QUEUE_ADDR, 8'hFF);
		rdChk(QUEUE_ADDR, 8'h07);
		wr(GAIN_ADDR, 8'hFF);
		rdChk(GAIN_ADDR, 8'h7F);
		wr(GAIN_ADDR, 8'h2F);
		wr(8'h40, 8'h5A);
		rdChk(8'h40, 8'h00);
		for (int c = 0; c < 8; c++) begin
			n = (c < 2) ? 1 : c;
			wr(QUEUE_ADDR, 8'(c));
			for (int k = 1; k <= n; k++) begin
				sample(16'h0004, 16'h0, 16'h0);
				`CHK("touch", k == n, touched[0])
			end
			for (int k = 1; k <= n; k++) begin
				sample(16'h0, 16'h0, 16'h0);
				`CHK("release", k != n, touched[0])
			end
		end
		wr(QUEUE_ADDR, 8'h03);
		for (int i = 0; i < 6; i++) begin
			sample(RUN0[i] ? 16'h4 : 16'h0, RUN1[i] ? 16'h4 : 16'h0, 16'h0);
			`CHK("broken run", {i >= 3, i == 5}, touched[1:0])
		end
		repeat (3) sample(16'h0, 16'h0, 16'h0);
		`CHK("all released", 14'h0, touched)
		wr(QUEUE_ADDR, 8'h01);
		for (int g = 0; g < 8; g++) begin
			wr(GAIN_ADDR, {1'b0, 3'(g), 4'hF});
			sample(16'h0001, 16'h0001, 16'h0);
			exp = (g == 0) ? 8'h7F : 8'(8'h80 >> g);
			`CHK("gain", exp, deltaCount[7:0])
			`CHK("shared gain", exp, deltaCount[15:8])
			`CHK("gain touch", exp > 8'h20, touched[0])
		end
		sample(16'hFF00, 16'h7FFF, 16'h8000);
		`CHK("delta caps", 16'h7FFF, deltaCount[15:0])
		`CHK("grouped neg cap", 8'hFF, deltaCount[79:72])
		rdChk(DELTA_BASE_ADDR, 8'hFF);
		rdChk(DELTA_BASE_ADDR + 8'h01, 8'h7F);
		for (int b = 0; b < 16; b++) begin
			wr(GAIN_ADDR, {4'h2, 4'(b)});
			sample(16'h0004, 16'h0, 16'h0);
			sh = (b > 8) ? 8 : b;
			exp = ((32'h1000 >> sh) > 32'hFF) ? 8'hFF : 8'(32'h1000 >> sh);
			`CHK("base", exp, baseCount[7:0])
			`CHK("base keeps touch", 1'b1, touched[0])
		end
		sample(16'h0, 16'h0, 16'h0004);
		`CHK("slider position", 7'h03, sliderValue)
		wr(SLIDER_ADDR, 8'h55);
		`CHK("slider locked", 7'h03, sliderValue)
		wr(OPTIONS_ADDR, 8'h69);
		wr(SLIDER_ADDR, 8'h55);
		`CHK("slider written", 7'h55, sliderValue)
		rdChk(SLIDER_ADDR, 8'h55);
		sample(16'h0, 16'h0, 16'h0);
		sample(16'h0, 16'h0, 16'h0004);
		`CHK("volume not position", 7'h55, sliderValue)
		for (int s = 0; s < 5; s++) stall(STALLS[s]);
		`CHK("line released", 2'b00, {sdaOe, sdaOut})
		end_of_test();
	end
endmodule : tb_touch_detect_config

`default_nettype wire
